// File: logic/pia_pkg.sv
// Summary of operation
// - 46 sources, four levels, some fixed
// - Within a level lowest source number wins
// - Signal request and branch address to core
// - Pending request wakes clocks in low power
// - Only sources enabled before sleep wake
// - Normal address is base joined to vector
// - Core mask bits block lower levels
// - Fast only on match and level 2
// - Fast address from slot low/high registers
// - Fast decided before the core answers
// - Exactly two fast slots
// - Initial fetch address driven after reset
// - Code 00 disables; others three ascending levels
// - Reserved priority bits read zero
package pia_pkg;
    localparam int         NSRC       = 46;
    localparam int         NPRIO      = 6;
    localparam int         VW         = 7;
    localparam int         VBAW       = 14;
    localparam int         AW         = 21;
    localparam int         FAHW       = 5;
    localparam int         NEV        = 2;
    localparam logic [7:0] IDX_PRIO0  = 8'h00;
    localparam logic [7:0] IDX_PRIO5  = 8'h10;
    localparam logic [7:0] IDX_VBA    = 8'h05;
    localparam logic [7:0] IDX_FM0    = 8'h06;
    localparam logic [7:0] IDX_FAL0   = 8'h07;
    localparam logic [7:0] IDX_FAH0   = 8'h08;
    localparam logic [7:0] IDX_FM1    = 8'h09;
    localparam logic [7:0] IDX_FAL1   = 8'h0A;
    localparam logic [7:0] IDX_FAH1   = 8'h0B;
    localparam logic [7:0] IDX_PEND0  = 8'h0C;
    localparam logic [7:0] IDX_PEND1  = 8'h0D;
    localparam logic [7:0] IDX_PEND2  = 8'h0E;
    localparam logic [7:0] IDX_CTRL   = 8'h12;
    localparam logic [7:0] IDX_ISTAT  = 8'h14;
    localparam logic [7:0] IDX_IMASK  = 8'h15;
    localparam int         EV_WAKE    = 0;
    localparam int         EV_FAST    = 1;
    localparam logic [1:0] CODE_OFF   = 2'h0;
    localparam logic [1:0] LVL_FAST   = 2'h2;
    localparam logic [1:0] LVL_FIXED  = 2'h3;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_ERR   = 2'h2;
    localparam logic [15:0] RST_REG16 = 16'h0000;
endpackage

// File: logic/pia_penc.sv
`timescale 1ns/10ps
`default_nettype none
module pia_penc #(
    parameter int N  = 46,
    parameter int IW = 6
) (
    input  wire logic [N-1:0]  req,
    output logic               found,
    output logic [IW-1:0]      index
);
    // Scan downward so the lowest set bit is left last
    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                index = IW'(i);
            end
        end
    end
endmodule // pia_penc
`default_nettype wire

// File: logic/pia_axil.sv
`timescale 1ns/10ps
`default_nettype none
module pia_axil (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [11:0] awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [11:0] araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [1:0]       rresp,
    output logic             wr_stb,
    output logic [7:0]       wr_idx,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    output logic             rd_stb,
    output logic [7:0]       rd_idx,
    input  wire logic        rd_err
);
    import pia_pkg::*;
    typedef struct packed {
        logic        aw_h;
        logic        w_h;
        logic [7:0]  aidx;
        logic [31:0] data;
        logic [3:0]  strb;
        logic        bv;
        logic [1:0]  br;
        logic        rv;
        logic [1:0]  rr;
        logic        rd;
        logic [7:0]  ridx;
        logic        aw_r, w_r, ar_r;
    } pia_axil_type;
    pia_axil_type s_q, s_d;

    assign awready = s_q.aw_r;
    assign wready  = s_q.w_r;
    assign arready = s_q.ar_r;
    assign wr_stb  = s_q.aw_h && s_q.w_h && !s_q.bv;
    assign wr_idx  = s_q.aidx;
    assign wr_data = s_q.data;
    assign wr_strb = s_q.strb;
    assign bvalid  = s_q.bv;
    assign bresp   = s_q.br;
    assign rvalid  = s_q.rv;
    assign rresp   = s_q.rr;

    assign rd_stb = s_q.rd;
    assign rd_idx = s_q.ridx;

    always_comb begin
        s_d = s_q;
        if (awvalid && awready) begin
            s_d.aw_h = 1'b1;
            s_d.aidx = awaddr[9:2];
        end
        if (wvalid && wready) begin
            s_d.w_h  = 1'b1;
            s_d.data = wdata;
            s_d.strb = wstrb;
        end
        if (wr_stb) begin
            s_d.aw_h = 1'b0;
            s_d.w_h  = 1'b0;
            s_d.bv   = 1'b1;
            s_d.br   = wr_err ? RESP_ERR : RESP_OKAY;
        end
        if (s_q.bv && bready) begin
            s_d.bv = 1'b0;
        end
        // Top registers read data on this edge
        if (s_q.rd) begin
            s_d.rv = 1'b1;
            s_d.rr = rd_err ? RESP_ERR : RESP_OKAY;
        end
        if (s_q.rv && rready) begin
            s_d.rv = 1'b0;
        end
        s_d.rd = arvalid && arready;
        if (s_d.rd) begin
            s_d.ridx = araddr[9:2];
        end
        s_d.aw_r = !s_d.aw_h && !s_d.bv;
        s_d.w_r  = !s_d.w_h && !s_d.bv;
        s_d.ar_r = !s_d.rv && !s_d.rd;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // pia_axil
`default_nettype wire

// File: logic/pia_top.sv
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pia_top
    import pia_pkg::*;
#(
    parameter logic [AW-1:0]   RESET_ADDR = 21'h000000,
    parameter logic [VW-1:0]   VEC_FIRST  = 7'h00,

    // Set bit: codes 01..11 mean levels 1..3 instead of 0..2
    parameter logic [NSRC-1:0] LVL_SHIFT  = '0,
    // Set bit: source always enabled at level 3, field ignored
    parameter logic [NSRC-1:0] FIXED_SRC  = '0
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [11:0]      s_axi_awaddr,
    input  wire logic [2:0]       s_axi_awprot,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    output logic [1:0]            s_axi_bresp,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    input  wire logic [11:0]      s_axi_araddr,
    input  wire logic [2:0]       s_axi_arprot,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,

    input  wire logic [NSRC-1:0]  irq_src,
    input  wire logic             core_mask_high,
    input  wire logic             core_mask_low,
    input  wire logic             low_power_mode,

    output logic                  core_irq_req,
    output logic [1:0]            core_irq_level,
    output logic [VW-1:0]         core_irq_vector,
    output logic                  core_irq_fast,
    output logic [AW-1:0]         core_vector_addr,
    output logic                  sysint_wake_req,
    output logic                  irq
);
    typedef struct packed {
        logic [NPRIO-1:0][15:0] prio;
        logic [VBAW-1:0]        vector_base;
        logic [1:0][VW-1:0]     fm;
        logic [1:0][15:0]       fal;
        logic [1:0][FAHW-1:0]   fah;

        logic [NSRC-1:0]        wake_en;
        logic                   lp;
        logic                   booted;
        logic                   req;
        logic [1:0]             lvl;
        logic [VW-1:0]          vec;
        logic                   fast;
        logic [AW-1:0]          addr;
        logic                   wake;

        logic [NEV-1:0]         ist;
        logic [NEV-1:0]         imask;
        logic                   irq;
        logic [31:0]            rdata;
    } pia_state_type;

    pia_state_type s_q, s_d;

    logic        wr_stb;
    logic [7:0]  wr_idx;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;

    logic        rd_stb;
    logic [7:0]  rd_idx;
    logic        rd_err;

    pia_axil u_axil (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .awaddr  (s_axi_awaddr),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .bresp   (s_axi_bresp),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .araddr  (s_axi_araddr),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rresp   (s_axi_rresp),

        .wr_stb  (wr_stb),
        .wr_idx  (wr_idx),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_stb  (rd_stb),
        .rd_idx  (rd_idx),
        .rd_err  (rd_err)
    );

    // Protection bits carry no meaning here
    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

    // Writable bits of a priority register; fields past the last source stay zero
    function automatic logic [15:0] prio_keep(input int r);
        logic [15:0] m;
        m = '0;
        for (int f = 0; f < 8; f++) begin
            if (r * 8 + f < NSRC) begin
                m[f*2 +: 2] = 2'h3;
            end
        end
        return m;
    endfunction

    // Merge a bus write into a 16-bit register by byte lanes
    function automatic logic [15:0] lane16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  st);
        logic [15:0] r;
        r = old;
        if (st[0]) begin
            r[7:0] = d[7:0];
        end
        if (st[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] i);
        return (i <= IDX_PEND2) || i == IDX_PRIO5 || i == IDX_CTRL ||
               i == IDX_ISTAT || i == IDX_IMASK;
    endfunction

    assign wr_err = !mapped(wr_idx);
    assign rd_err = !mapped(rd_idx);

    // Per-source enable and level
    logic [NSRC-1:0]       src_en;
    logic [NSRC-1:0][1:0]  src_lvl;
    logic [3:0][NSRC-1:0]  lvl_req;
    logic [3:0]            lvl_found;
    logic [3:0][5:0]       lvl_idx;
    logic [1:0]            mask_lvl;

    always_comb begin
        for (int s = 0; s < NSRC; s++) begin
            logic [1:0] code;
            code = s_q.prio[s / 8][(s % 8) * 2 +: 2];
            if (FIXED_SRC[s]) begin
                src_en[s]  = 1'b1;
                src_lvl[s] = LVL_FIXED;
            end else begin
                src_en[s]  = code != CODE_OFF;
                src_lvl[s] = code - 2'h1 + {1'b0, LVL_SHIFT[s]};
            end
        end

        for (int l = 0; l < 4; l++) begin
            for (int s = 0; s < NSRC; s++) begin
                lvl_req[l][s] = irq_src[s] && src_en[s] && src_lvl[s] == 2'(l);
            end
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_lvl
        pia_penc #(
            .N  (NSRC),
            .IW (6)
        ) u_penc (
            .req   (lvl_req[g]),
            .found (lvl_found[g]),
            .index (lvl_idx[g])
        );
    end

    assign mask_lvl = {core_mask_high, core_mask_low};

    // Winner selection, fast match and address forming
    logic            win_req;
    logic [1:0]      win_lvl;
    logic [VW-1:0]   win_vec;
    logic            win_fast;
    logic            win_slot;
    logic [AW-1:0]   win_addr;

    always_comb begin
        win_req = 1'b0;
        win_lvl = 2'h0;
        win_vec = VEC_FIRST;

        for (int l = 0; l < 4; l++) begin
            if (lvl_found[l] && 2'(l) >= mask_lvl) begin
                win_req = 1'b1;
                win_lvl = 2'(l);
                win_vec = VW'(lvl_idx[l]) + VEC_FIRST;
            end
        end

        win_slot = win_vec != s_q.fm[0];
        win_fast = win_req && win_lvl == LVL_FAST &&
                   (win_vec == s_q.fm[0] || win_vec == s_q.fm[1]);

        if (win_fast) begin
            win_addr = {s_q.fah[win_slot], s_q.fal[win_slot]};
        end else begin
            win_addr = {s_q.vector_base, win_vec};
        end
    end

    // Read mux
    function automatic logic [31:0] rd_word(input pia_state_type s,
                                            input logic [7:0] i,
                                            input logic [NSRC-1:0] p);
        logic [47:0] pp;
        pp = {2'h0, p};
        unique case (i)
            IDX_VBA:   return 32'(s.vector_base);
            IDX_FM0:   return 32'(s.fm[0]);
            IDX_FAL0:  return 32'(s.fal[0]);
            IDX_FAH0:  return 32'(s.fah[0]);
            IDX_FM1:   return 32'(s.fm[1]);
            IDX_FAL1:  return 32'(s.fal[1]);
            IDX_FAH1:  return 32'(s.fah[1]);

            IDX_PEND0: return 32'(pp[15:0]);
            IDX_PEND1: return 32'(pp[31:16]);
            IDX_PEND2: return 32'(pp[47:32]);
            IDX_PRIO5: return 32'(s.prio[5]);
            IDX_CTRL:  return 32'({s.lvl, s.req, s.fast, s.wake, s.lp,
                                   core_mask_high, core_mask_low});
            IDX_ISTAT: return 32'(s.ist);
            IDX_IMASK: return 32'(s.imask);
            default: begin
                if (i < 8'(NPRIO - 1)) begin
                    return 32'(s.prio[i[2:0]]);
                end
                return 32'h0000_0000;
            end
        endcase
    endfunction

    always_comb begin
        logic [NEV-1:0] ev;
        s_d = s_q;
        ev  = '0;

        if (wr_stb) begin
            for (int r = 0; r < NPRIO; r++) begin
                if (wr_idx == (r == 5 ? IDX_PRIO5 : IDX_PRIO0 + 8'(r))) begin
                    s_d.prio[r] = lane16(s_q.prio[r], wr_data, wr_strb) &
                                  prio_keep(r);
                end
            end

            unique case (wr_idx)
                IDX_VBA:   s_d.vector_base = VBAW'(lane16(16'(s_q.vector_base), wr_data, wr_strb));
                IDX_FM0:   s_d.fm[0] = VW'(lane16(16'(s_q.fm[0]), wr_data, wr_strb));
                IDX_FAL0:  s_d.fal[0] = lane16(s_q.fal[0], wr_data, wr_strb);
                IDX_FAH0:  s_d.fah[0] = FAHW'(lane16(16'(s_q.fah[0]), wr_data, wr_strb));
                IDX_FM1:   s_d.fm[1] = VW'(lane16(16'(s_q.fm[1]), wr_data, wr_strb));
                IDX_FAL1:  s_d.fal[1] = lane16(s_q.fal[1], wr_data, wr_strb);
                IDX_FAH1:  s_d.fah[1] = FAHW'(lane16(16'(s_q.fah[1]), wr_data, wr_strb));

                IDX_IMASK: s_d.imask = wr_strb[0] ? wr_data[NEV-1:0] : s_q.imask;
                IDX_ISTAT: s_d.ist = wr_strb[0] ? s_q.ist & ~wr_data[NEV-1:0] : s_q.ist;
                default:   s_d.vector_base = s_q.vector_base;
            endcase
        end

        if (rd_stb) begin
            s_d.rdata = rd_word(s_q, rd_idx, irq_src);
        end

        // Snapshot enables at the moment the core goes to sleep
        s_d.lp = low_power_mode;
        if (low_power_mode && !s_q.lp) begin
            s_d.wake_en = src_en;
        end

        s_d.wake = low_power_mode && |(irq_src & s_q.wake_en);
        if (s_d.wake && !s_q.wake) begin
            ev[EV_WAKE] = 1'b1;
        end

        // Registered each clock; fast decision ready with the request
        s_d.req  = win_req;
        s_d.lvl  = win_lvl;
        s_d.vec  = win_vec;
        s_d.fast = win_fast;

        if (win_req) begin
            s_d.booted = 1'b1;
        end
        // Boot address stays up until the first request appears
        if (win_req || s_q.booted) begin
            s_d.addr = win_addr;
        end

        if (win_fast && !(s_q.req && s_q.fast && s_q.vec == win_vec)) begin
            ev[EV_FAST] = 1'b1;
        end

        // Set after clear so a same-cycle event is kept
        s_d.ist = s_d.ist | ev;
        s_d.irq = |(s_d.ist & s_d.imask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q      <= '0;
            s_q.addr <= RESET_ADDR;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_rdata      = s_q.rdata;

    assign core_irq_req     = s_q.req;
    assign core_irq_level   = s_q.lvl;
    assign core_irq_vector  = s_q.vec;
    assign core_irq_fast    = s_q.fast;
    assign core_vector_addr = s_q.addr;
    assign sysint_wake_req  = s_q.wake;

    assign irq              = s_q.irq;
endmodule // pia_top
`default_nettype wire

// File: dv/pia_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pia_checker
    import pia_pkg::*;
#(
    parameter logic [AW-1:0] RESET_ADDR = 21'h000000,
    parameter logic [VW-1:0] VEC_FIRST  = 7'h00
) (
    input wire logic            aclk,
    input wire logic            aresetn,
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_wvalid,
    input wire logic            s_axi_wready,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic            s_axi_rvalid,
    input wire logic [1:0]      s_axi_bresp,
    input wire logic [NSRC-1:0] irq_src,
    input wire logic            core_mask_high,
    input wire logic            core_mask_low,
    input wire logic            low_power_mode,
    input wire logic            core_irq_req,
    input wire logic [1:0]      core_irq_level,
    input wire logic [VW-1:0]   core_irq_vector,
    input wire logic            core_irq_fast,
    input wire logic [AW-1:0]   core_vector_addr,
    input wire logic            sysint_wake_req
);
    // Inputs as the design saw them one edge earlier
    logic [1:0]      mask_q;
    logic [NSRC-1:0] src_q;
    always_ff @(posedge aclk) begin
        mask_q <= {core_mask_high, core_mask_low};
        src_q  <= irq_src;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_addr: assert property ($rose(aresetn) |->
        core_vector_addr == RESET_ADDR && !core_irq_req) else $error("bad reset address");
    a_mask_level: assert property (core_irq_req |-> core_irq_level >= mask_q)
        else $error("masked level presented");
    a_fast_level: assert property (core_irq_fast |->
        core_irq_req && core_irq_level == LVL_FAST) else $error("fast not at level two");
    a_idle_quiet: assert property (src_q == '0 |-> !core_irq_req)
        else $error("request with no source");
    a_winner_live: assert property (core_irq_req |->
        src_q[core_irq_vector - VEC_FIRST]) else $error("winner was not active");
    a_normal_addr: assert property (core_irq_req && !core_irq_fast |->
        core_vector_addr[VW-1:0] == core_irq_vector) else $error("vector not in address");
    a_wake_sleep: assert property (sysint_wake_req |-> $past(low_power_mode))
        else $error("wake outside low power");
    a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write response");
    a_r_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("late read data");
    a_ar_block: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
        else $error("second read accepted");
    c_fast: cover property (core_irq_fast);
    c_wake: cover property (sysint_wake_req);
    c_top: cover property (core_irq_req && core_irq_level == 2'h3);
    c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_ERR);
endmodule // pia_checker
bind pia_top pia_checker #(.RESET_ADDR(RESET_ADDR), .VEC_FIRST(VEC_FIRST)) u_chk (.*);
`default_nettype wire

// File: dv/pia_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module pia_core_model
    import pia_pkg::*;
#(
    // Handler address holding a subroutine jump; arbitrary
    parameter logic [AW-1:0] JUMP_ADDR = 21'h1FFFF0
) (
    input wire logic          aclk,
    input wire logic          aresetn,
    input wire logic [1:0]    mask_cmd,
    input wire logic          lp_cmd,
    input wire logic          core_irq_req,
    input wire logic          core_irq_fast,
    input wire logic [AW-1:0] core_vector_addr,
    output logic              core_mask_high,
    output logic              core_mask_low,
    output logic              low_power_mode,
    output logic              fast_mode_q
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {core_mask_high, core_mask_low} <= 2'h0;
            low_power_mode <= 1'h0;
            fast_mode_q <= 1'h0;
        end else begin
            {core_mask_high, core_mask_low} <= mask_cmd;
            // Sleep is left by command only, so wake stays visible
            low_power_mode <= lp_cmd;
            fast_mode_q <= core_irq_req && core_irq_fast && core_vector_addr != JUMP_ADDR;
        end
    end
endmodule // pia_core_model
`default_nettype wire

// File: dv/pia_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pia_top_tb;
    import pia_pkg::*;
    localparam logic [AW-1:0]   RST_A = 21'h0ABCDE;
    localparam logic [NSRC-1:0] SHIFT = 46'h2;
    localparam logic [NSRC-1:0] FIXED = 46'h1000_0000_0000;
    localparam logic [13:0]     VB    = 14'h2A5C;
    logic            aclk = 1'h0, aresetn = 1'h0;
    logic            s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic            s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0]     s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [2:0]      s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0]     s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]      s_axi_wstrb = 4'hF;
    logic [1:0]      s_axi_bresp, s_axi_rresp, core_irq_level, lv, mask_cmd = 2'h0;
    logic [NSRC-1:0] irq_src = '0;
    logic            core_mask_high, core_mask_low, low_power_mode, lp_cmd = 1'h0;
    logic            core_irq_req, core_irq_fast, sysint_wake_req, irq, fast_mode_q;
    logic [VW-1:0]   core_irq_vector;
    logic [AW-1:0]   core_vector_addr;
    logic [15:0]     pr [0:5];
    int              err_total = 0, n_checks = 0;
    always #5 aclk = ~aclk;
    pia_top #(.RESET_ADDR(RST_A), .LVL_SHIFT(SHIFT), .FIXED_SRC(FIXED)) DUT (.*);
    pia_core_model CORE (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cc(input logic [31:0] e);
        chk({core_irq_req, core_irq_level, core_irq_vector, core_irq_fast, core_vector_addr}, e);
    endtask
    // Each access opens on a fresh edge
    task automatic wr(input logic [7:0] i, input logic [15:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (n < 40) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'h0;
                chk(s_axi_bresp, er);
                n = 99;
            end
        end
        if (n == 40) chk(32'h0, 32'h1);
    endtask
    task automatic rd(input logic [7:0] i, input logic [15:0] ed, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (n < 40) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'h0;
                chk(s_axi_rdata, {16'h0000, ed});
                chk(s_axi_rresp, er);
                n = 99;
            end
        end
        if (n == 40) chk(32'h0, 32'h1);
    endtask
    task automatic setp(input int s, input logic [1:0] c);
        int k;
        k = s / 8;
        pr[k][(s % 8) * 2 +: 2] = c;
        wr((k == 5) ? IDX_PRIO5 : 8'(k), pr[k], RESP_OKAY);
    endtask
    // Mask takes one edge more via the core model
    task automatic st();
        repeat (4) @(posedge aclk);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d, checks %0d", err_total, n_checks);
        if (err_total == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        report_and_stop();
    end
    initial begin
        pr = '{default: 16'h0000};
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        cc({1'h0, 2'h0, 7'h00, 1'h0, RST_A});
        rd(IDX_PRIO0, 16'h0000, RESP_OKAY);
        wr(IDX_PRIO5, 16'hFFFF, RESP_OKAY);
        rd(IDX_PRIO5, 16'h0FFF, RESP_OKAY);
        wr(IDX_PRIO5, 16'h0000, RESP_OKAY);
        wr(8'h3F, 16'h1234, RESP_ERR);
        rd(8'h3F, 16'h0000, RESP_ERR);
        wr(IDX_VBA, {2'h0, VB}, RESP_OKAY);
        setp(3, 2'h1);
        setp(5, 2'h1);
        irq_src <= 46'h20;
        st();
        cc({1'h1, 2'h0, 7'h05, 1'h0, VB, 7'h05});
        irq_src <= 46'h28;
        st();
        cc({1'h1, 2'h0, 7'h03, 1'h0, VB, 7'h03});
        rd(IDX_PEND0, 16'h0028, RESP_OKAY);
        setp(9, 2'h3);
        irq_src <= 46'h228;
        st();
        cc({1'h1, 2'h2, 7'h09, 1'h0, VB, 7'h09});
        irq_src <= 46'h1000_0000_0228;
        st();
        cc({1'h1, 2'h3, 7'h2C, 1'h0, VB, 7'h2C});
        irq_src <= '0;
        setp(5, 2'h0);
        for (int m = 0; m < 4; m++) begin
            for (int c = 1; c < 4; c++) begin
                for (int s = 1; s < 4; s += 2) begin
                    setp(s, 2'(c));
                    lv = 2'(c - 1 + (s == 1));
                    mask_cmd <= 2'(m);
                    irq_src <= 46'h1 << s;
                    st();
                    chk(core_irq_req, lv >= 2'(m));
                    if (lv >= 2'(m)) chk(core_irq_level, lv);
                    setp(s, 2'h0);
                end
            end
        end
        mask_cmd <= 2'h0;
        irq_src <= 46'h8;
        st();
        chk(core_irq_req, 32'h0);
        wr(IDX_IMASK, 16'h0000, RESP_OKAY);
        wr(IDX_FM0, 16'h0009, RESP_OKAY);
        wr(IDX_FAL0, 16'hBEEF, RESP_OKAY);
        wr(IDX_FAH0, 16'h0011, RESP_OKAY);
        irq_src <= 46'h200;
        st();
        cc({1'h1, 2'h2, 7'h09, 1'h1, 5'h11, 16'hBEEF});
        chk(fast_mode_q, 32'h1);
        chk(irq, 32'h0);
        rd(IDX_ISTAT, 16'h0002, RESP_OKAY);
        wr(IDX_IMASK, 16'h0002, RESP_OKAY);
        st();
        chk(irq, 32'h1);
        wr(IDX_ISTAT, 16'h0002, RESP_OKAY);
        st();
        chk(irq, 32'h0);
        wr(IDX_FM1, 16'h000C, RESP_OKAY);
        wr(IDX_FAL1, 16'h1357, RESP_OKAY);
        wr(IDX_FAH1, 16'h000A, RESP_OKAY);
        setp(12, 2'h3);
        irq_src <= 46'h1000;
        st();
        cc({1'h1, 2'h2, 7'h0C, 1'h1, 5'h0A, 16'h1357});
        setp(12, 2'h2);
        st();
        cc({1'h1, 2'h1, 7'h0C, 1'h0, VB, 7'h0C});
        irq_src <= '0;
        setp(20, 2'h1);
        lp_cmd <= 1'h1;
        st();
        irq_src <= 46'h10_0000;
        st();
        chk(sysint_wake_req, 32'h1);
        rd(IDX_ISTAT, 16'h0003, RESP_OKAY);
        lp_cmd <= 1'h0;
        irq_src <= '0;
        st();
        chk(sysint_wake_req, 32'h0);
        lp_cmd <= 1'h1;
        st();
        setp(21, 2'h1);
        irq_src <= 46'h20_0000;
        st();
        chk(sysint_wake_req, 32'h0);
        lp_cmd <= 1'h0;
        report_and_stop();
    end
endmodule // pia_top_tb
`default_nettype wire
